// ---- pkg/ompl_defs.svh ----
// Purpose: Offsets, field positions, reset values and opcodes of the executor
// Assumes: Included by its bare name after the package
// Notes:   Definitions only
`ifndef OMPL_DEFS_SVH
`define OMPL_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OMPL_OFS_CTRL      8'h00
`define OMPL_OFS_ACC       8'h04
`define OMPL_OFS_STATUS    8'h08
`define OMPL_OFS_BANK      8'h0C
`define OMPL_OFS_PTR0      8'h10
`define OMPL_OFS_PTR1      8'h14
`define OMPL_OFS_PTR2      8'h18

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define OMPL_CTRL_RUN      0
`define OMPL_ST_ZERO       0
`define OMPL_ST_SIGN       1
`define OMPL_ST_UNKNOWN    2
`define OMPL_ST_BAD2       3
`define OMPL_ST_BUSY       4
`define OMPL_RST_CTRL      1'h1
`define OMPL_RST_ACC       8'h00
`define OMPL_RST_BANK      4'h0
`define OMPL_RST_PTR       12'h000

// ----------------------------------------------------------------------------
// Opcode prefixes and access bank layout
// ----------------------------------------------------------------------------
`define OMPL_OPC_OR_LIT    8'h09
`define OMPL_OPC_OR_FILE   6'h04
`define OMPL_OPC_MOVE      6'h14
`define OMPL_OPC_PLD_FIRST 10'h3B8
`define OMPL_OPC_PLD_SECND 8'hF0
`define OMPL_ACCESS_SPLIT  8'h80
`define OMPL_ACCESS_HI     4'hF
`define OMPL_ACCESS_LO     4'h0

`endif

// ---- pkg/ompl_pkg.sv ----
// Purpose: Types shared by the executor modules
// Assumes: Nothing
// Notes:   Constants live in ompl_defs.svh
package ompl_pkg;

  // Decoded operation
  typedef enum logic [4:0] {
    OMPL_OP_UNKNOWN = 5'h01,
    OMPL_OP_OR_LIT  = 5'h02,
    OMPL_OP_OR_FILE = 5'h04,
    OMPL_OP_MOVE    = 5'h08,
    OMPL_OP_PLD     = 5'h10
  } ompl_op_t;

  // Execution phase, one-hot
  typedef enum logic [4:0] {
    OMPL_ST_IDLE  = 5'h01,
    OMPL_ST_Q2    = 5'h02,
    OMPL_ST_Q3    = 5'h04,
    OMPL_ST_Q4    = 5'h08,
    OMPL_ST_WAIT2 = 5'h10
  } ompl_state_t;

endpackage

// ---- pkg/ompl_dec_if.sv ----
// Purpose: Carries an instruction word and its decoded fields
// Assumes: One decoder, one consumer
// Notes:   Purely combinational signals
`timescale 1ns/10ps
`default_nettype none
interface ompl_dec_if;
  import ompl_pkg::*;
  logic [15:0] word;        // Word under decode
  ompl_op_t    op;          // Decoded operation
  logic        to_file;     // Destination bit
  logic        use_bank;    // Bank-access bit
  logic [7:0]  faddr;       // File address / literal byte
  logic [1:0]  ptr_sel;     // Pointer selector
  logic [3:0]  lit_hi;      // Literal bits 11..8
  logic        second_ok;   // Word is a valid pointer-load second word

  modport dec  (input word, output op, to_file, use_bank, faddr, ptr_sel, lit_hi, second_ok);
  modport core (output word, input op, to_file, use_bank, faddr, ptr_sel, lit_hi, second_ok);
endinterface
`default_nettype wire

// ---- hdl/ompl_decode.sv ----
// Purpose: Opcode decoder for the four supported instructions
// Assumes: 16-bit instruction words
// Notes:   Anything else decodes as unknown
`timescale 1ns/10ps
`default_nettype none
`include "ompl_defs.svh"
module ompl_decode
  import ompl_pkg::*;
(
  ompl_dec_if.dec d
);

  // ---------------------------------------------------------------------------
  // Field extraction and opcode match
  // ---------------------------------------------------------------------------
  always_comb begin
    d.to_file   = d.word[9];
    d.use_bank  = d.word[8];
    d.faddr     = d.word[7:0];
    d.ptr_sel   = d.word[5:4];
    d.lit_hi    = d.word[3:0];
    d.second_ok = (d.word[15:8] == `OMPL_OPC_PLD_SECND);
    if (d.word[15:8] == `OMPL_OPC_OR_LIT) begin
      d.op = OMPL_OP_OR_LIT;
    end else if (d.word[15:10] == `OMPL_OPC_OR_FILE) begin
      d.op = OMPL_OP_OR_FILE;
    end else if (d.word[15:10] == `OMPL_OPC_MOVE) begin
      d.op = OMPL_OP_MOVE;
    end else if (d.word[15:6] == `OMPL_OPC_PLD_FIRST && d.word[5:4] != 2'h3) begin
      d.op = OMPL_OP_PLD;
    end else begin
      d.op = OMPL_OP_UNKNOWN;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/ompl_addr_map.sv ----
// Purpose: Forms the 12-bit data address of a file operand
// Assumes: Bank pointer is 4 bits
// Notes:   Access bank splits at ACCESS_SPLIT
`timescale 1ns/10ps
`default_nettype none
`include "ompl_defs.svh"
module ompl_addr_map #(
  parameter logic [7:0] ACCESS_SPLIT = `OMPL_ACCESS_SPLIT
) (
  input  wire logic [7:0]  faddr,
  input  wire logic        use_bank,
  input  wire logic [3:0]  bank,
  output logic      [11:0] addr
);

  // ---------------------------------------------------------------------------
  // Bank select
  // ---------------------------------------------------------------------------
  always_comb begin
    if (use_bank) begin
      addr = {bank, faddr};
    end else if (faddr < ACCESS_SPLIT) begin
      addr = {`OMPL_ACCESS_LO, faddr};
    end else begin
      addr = {`OMPL_ACCESS_HI, faddr};
    end
  end

endmodule
`default_nettype wire

// ---- hdl/ompl_core.sv ----
// Purpose: Executes OR-literal, OR-file, move-file and pointer-load
// Assumes: Data memory reads with one cycle latency, writes on the clock edge
// Notes:   Four clocks per instruction cycle, Q1 to Q4
//
// Contract
// - OR literal into accumulator, sets N and Z
// - Move-file updates only N and Z
// - Prefix 0101 00 decodes move-file, one cycle
// - Destination 0 sends value to accumulator
// - Destination 1 writes value back to file
// - File address picks any of 256 bytes
// - Bank-access 0 uses fixed access bank
// - Bank-access 1 uses bank pointer upper bits
// - Pointer load: high part, then low byte
// - Pointer load words 1110 1110 00, 1111 0000
`timescale 1ns/10ps
`default_nettype none
`include "ompl_defs.svh"
module ompl_core
  import ompl_pkg::*;
#(
  parameter logic [7:0] ACCESS_SPLIT = `OMPL_ACCESS_SPLIT,
  parameter int         NUM_PTRS     = 3
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  output logic             instr_ready,
  output logic      [11:0] dmem_addr,
  output logic             dmem_rd,
  output logic             dmem_we,
  output logic      [7:0]  dmem_wdata,
  input  wire logic [7:0]  dmem_rdata
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------
  // Merge bus write data into an old word by byte lanes
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Sign and zero flags of a result, {sign, zero}
  function automatic logic [1:0] nz_of(input logic [7:0] v);
    return {v[7], (v == 8'h00)};
  endfunction

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  ompl_dec_if  dec ();                       // Decoder carrier
  logic [11:0] map_addr;                     // Mapped file address
  ompl_state_t state_q, state_d;             // Execution phase
  logic [15:0] ir_q, ir_d;                   // Instruction register
  logic        second_q, second_d;           // Executing second pointer-load word
  logic [1:0]  sel_q, sel_d;                 // Pointer selected by first word
  logic [7:0]  result_q, result_d;           // Q3 result
  logic [7:0]  acc_q, acc_d;                 // Accumulator
  logic        zf_q, zf_d;                   // All-clear flag
  logic        nf_q, nf_d;                   // Sign-result flag
  logic        unk_q, unk_d;                 // Sticky unknown opcode
  logic        bad2_q, bad2_d;               // Sticky bad second word
  logic        run_q, run_d;                 // Run enable
  logic [3:0]  bank_q, bank_d;               // Bank pointer register
  logic [11:0] ptr_q [NUM_PTRS];             // Indirect pointer registers
  logic [11:0] ptr_d [NUM_PTRS];
  logic [11:0] daddr_q, daddr_d;             // Data memory address
  logic        drd_q, drd_d;                 // Data memory read strobe
  logic        dwe_q, dwe_d;                 // Data memory write strobe
  logic [7:0]  dwdata_q, dwdata_d;           // Data memory write data
  logic        ack_q, ack_d;                 // Bus acknowledge
  logic [31:0] rdata_q, rdata_d;             // Bus read data
  logic [31:0] rd_mux;                       // Register read selection
  logic [31:0] wr_val;                       // Byte-merged write value
  logic        bus_req;                      // Request on the bus
  logic        sw_wr;                        // Write takes effect now
  logic        accepting;                    // Word taken this cycle
  logic [1:0]  nz;                           // Flags of the Q3 result

  // ---------------------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------------------
  ompl_decode u_decode (
    .d (dec.dec)
  );

  ompl_addr_map #(
    .ACCESS_SPLIT (ACCESS_SPLIT)
  ) u_addr_map (
    .faddr    (dec.faddr),
    .use_bank (dec.use_bank),
    .bank     (bank_q),
    .addr     (map_addr)
  );

  // ---------------------------------------------------------------------------
  // Fetch handshake and outputs
  // ---------------------------------------------------------------------------
  // Words are taken only in Q1 of an instruction cycle
  assign instr_ready = run_q & (state_q == OMPL_ST_IDLE || state_q == OMPL_ST_WAIT2);
  assign accepting   = instr_ready & instr_valid;
  // Incoming word is decoded in Q1, the held one afterwards
  assign dec.word    = accepting ? instr_word : ir_q;
  assign dmem_addr   = daddr_q;
  assign dmem_rd     = drd_q;
  assign dmem_we     = dwe_q;
  assign dmem_wdata  = dwdata_q;
  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = rdata_q;
  assign nz          = nz_of(result_q);

  // ---------------------------------------------------------------------------
  // Register read selection
  // ---------------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (wb_adr_i == `OMPL_OFS_CTRL) begin
      rd_mux[`OMPL_CTRL_RUN] = run_q;
    end else if (wb_adr_i == `OMPL_OFS_ACC) begin
      rd_mux[7:0] = acc_q;
    end else if (wb_adr_i == `OMPL_OFS_STATUS) begin
      rd_mux[`OMPL_ST_ZERO]    = zf_q;
      rd_mux[`OMPL_ST_SIGN]    = nf_q;
      rd_mux[`OMPL_ST_UNKNOWN] = unk_q;
      rd_mux[`OMPL_ST_BAD2]    = bad2_q;
      rd_mux[`OMPL_ST_BUSY]    = (state_q != OMPL_ST_IDLE);
    end else if (wb_adr_i == `OMPL_OFS_BANK) begin
      rd_mux[3:0] = bank_q;
    end else if (wb_adr_i == `OMPL_OFS_PTR0) begin
      rd_mux[11:0] = ptr_q[0];
    end else if (wb_adr_i == `OMPL_OFS_PTR1) begin
      rd_mux[11:0] = ptr_q[1];
    end else if (wb_adr_i == `OMPL_OFS_PTR2) begin
      rd_mux[11:0] = ptr_q[2];
    end else begin
      rd_mux = 32'h0000_0000;                // Unmapped reads zero
    end
  end

  // ---------------------------------------------------------------------------
  // Bus slave next state
  // ---------------------------------------------------------------------------
  always_comb begin
    bus_req = wb_cyc_i & wb_stb_i;
    ack_d   = bus_req & ~ack_q;               // One-cycle ack, drops after
    rdata_d = ack_d ? rd_mux : rdata_q;
    sw_wr   = bus_req & wb_we_i & ack_q;      // Write lands on the ack edge
    wr_val  = wb_merge(rd_mux, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Execution next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    ir_d     = ir_q;
    second_d = second_q;
    sel_d    = sel_q;
    result_d = result_q;
    acc_d    = acc_q;
    zf_d     = zf_q;
    nf_d     = nf_q;
    unk_d    = unk_q;
    bad2_d   = bad2_q;
    run_d    = run_q;
    bank_d   = bank_q;
    ptr_d    = ptr_q;
    daddr_d  = daddr_q;
    drd_d    = 1'b0;
    dwe_d    = 1'b0;
    dwdata_d = dwdata_q;
    // Software writes first; hardware below overrides them
    if (sw_wr) begin
      if (wb_adr_i == `OMPL_OFS_CTRL) begin
        run_d = wr_val[`OMPL_CTRL_RUN];
      end else if (wb_adr_i == `OMPL_OFS_ACC) begin
        acc_d = wr_val[7:0];
      end else if (wb_adr_i == `OMPL_OFS_STATUS) begin
        zf_d   = wr_val[`OMPL_ST_ZERO];
        nf_d   = wr_val[`OMPL_ST_SIGN];
        unk_d  = unk_q & ~wr_val[`OMPL_ST_UNKNOWN];   // Write one clears
        bad2_d = bad2_q & ~wr_val[`OMPL_ST_BAD2];
      end else if (wb_adr_i == `OMPL_OFS_BANK) begin
        bank_d = wr_val[3:0];
      end else if (wb_adr_i == `OMPL_OFS_PTR0) begin
        ptr_d[0] = wr_val[11:0];
      end else if (wb_adr_i == `OMPL_OFS_PTR1) begin
        ptr_d[1] = wr_val[11:0];
      end else if (wb_adr_i == `OMPL_OFS_PTR2) begin
        ptr_d[2] = wr_val[11:0];
      end
    end
    case (state_q)
      // Q1: take a word, decode it, start the operand read
      OMPL_ST_IDLE, OMPL_ST_WAIT2: begin
        if (accepting) begin
          ir_d     = instr_word;
          second_d = (state_q == OMPL_ST_WAIT2);
          daddr_d  = map_addr;
          drd_d    = (state_q == OMPL_ST_IDLE) &&
                     (dec.op == OMPL_OP_OR_FILE || dec.op == OMPL_OP_MOVE);
          state_d  = OMPL_ST_Q2;
        end
      end
      // Q2: memory read in flight
      OMPL_ST_Q2: begin
        state_d = OMPL_ST_Q3;
      end
      // Q3: process data, queue a file write-back
      OMPL_ST_Q3: begin
        if (dec.op == OMPL_OP_OR_LIT) begin
          result_d = acc_q | dec.faddr;
        end else if (dec.op == OMPL_OP_OR_FILE) begin
          result_d = acc_q | dmem_rdata;
        end else begin
          result_d = dmem_rdata;
        end
        if (!second_q && dec.to_file &&
            (dec.op == OMPL_OP_OR_FILE || dec.op == OMPL_OP_MOVE)) begin
          dwe_d    = 1'b1;
          dwdata_d = (dec.op == OMPL_OP_OR_FILE) ? (acc_q | dmem_rdata) : dmem_rdata;
        end
        state_d = OMPL_ST_Q4;
      end
      // Q4: write accumulator, flags or pointer
      OMPL_ST_Q4: begin
        state_d = OMPL_ST_IDLE;
        if (second_q) begin
          second_d = 1'b0;
          if (dec.second_ok) begin
            ptr_d[sel_q][7:0] = ir_q[7:0];
          end else begin
            bad2_d = 1'b1;                                              // Set beats clear
          end
        end else begin
          case (dec.op)
            OMPL_OP_OR_LIT: begin
              acc_d = result_q;
              nf_d  = nz[1];
              zf_d  = nz[0];
            end
            OMPL_OP_OR_FILE, OMPL_OP_MOVE: begin
              if (!dec.to_file) begin
                acc_d = result_q;
              end
              nf_d = nz[1];
              zf_d = nz[0];
            end
            OMPL_OP_PLD: begin
              ptr_d[dec.ptr_sel][11:8] = dec.lit_hi;
              sel_d   = dec.ptr_sel;
              state_d = OMPL_ST_WAIT2;
            end
            default: begin
              unk_d = 1'b1;                                             // Set beats clear
            end
          endcase
        end
      end
      default: begin
        state_d = OMPL_ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Execution registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q  <= OMPL_ST_IDLE;
      ir_q     <= 16'h0000;
      second_q <= 1'b0;
      sel_q    <= 2'h0;
      result_q <= 8'h00;
      acc_q    <= `OMPL_RST_ACC;
      zf_q     <= 1'b0;
      nf_q     <= 1'b0;
      unk_q    <= 1'b0;
      bad2_q   <= 1'b0;
      run_q    <= `OMPL_RST_CTRL;
      bank_q   <= `OMPL_RST_BANK;
      for (int i = 0; i < NUM_PTRS; i++) begin
        ptr_q[i] <= `OMPL_RST_PTR;
      end
      daddr_q  <= 12'h000;
      drd_q    <= 1'b0;
      dwe_q    <= 1'b0;
      dwdata_q <= 8'h00;
    end else begin
      state_q  <= state_d;
      ir_q     <= ir_d;
      second_q <= second_d;
      sel_q    <= sel_d;
      result_q <= result_d;
      acc_q    <= acc_d;
      zf_q     <= zf_d;
      nf_q     <= nf_d;
      unk_q    <= unk_d;
      bad2_q   <= bad2_d;
      run_q    <= run_d;
      bank_q   <= bank_d;
      ptr_q    <= ptr_d;
      daddr_q  <= daddr_d;
      drd_q    <= drd_d;
      dwe_q    <= dwe_d;
      dwdata_q <= dwdata_d;
    end
  end

endmodule
`default_nettype wire

// ---- bench/ompl_core_checker.sv ----
// Purpose: Port-level checks of the instruction executor
// Assumes: Sees only the top module ports
// Notes:   Bound at the foot
`timescale 1ns/10ps
`default_nettype none
`include "ompl_defs.svh"
module ompl_checker #(
  parameter logic [7:0] ACCESS_SPLIT = `OMPL_ACCESS_SPLIT,
  parameter int         NUM_PTRS     = 3
) (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic        instr_ready,
  input wire logic [11:0] dmem_addr,
  input wire logic        dmem_rd,
  input wire logic        dmem_we,
  input wire logic [7:0]  dmem_wdata,
  input wire logic [7:0]  dmem_rdata
);
  // ------
  // Helper decode
  // ------
  logic       take;      // Word accepted this edge
  logic       file_op;   // OR-file or move-file word
  logic       file_take; // File word accepted
  logic       pld_one;   // Valid pointer-load first word
  logic       wait2_q;   // Second word is due
  logic       wait2_d;   // Next second-word flag
  logic [7:0] f;         // File address field
  assign take      = instr_valid && instr_ready;
  assign f         = instr_word[7:0];
  assign file_op   = !wait2_q && (instr_word[15:10] == `OMPL_OPC_MOVE || instr_word[15:10] == `OMPL_OPC_OR_FILE);
  assign file_take = take && file_op;
  assign pld_one   = !wait2_q && instr_word[15:6] == `OMPL_OPC_PLD_FIRST && instr_word[5:4] != 2'h3;
  // Next second-word flag
  always_comb begin
    wait2_d = wait2_q;
    if (take) begin
      wait2_d = pld_one;
    end
  end
  // Second-word flag
  always_ff @(posedge core_clk) begin
    wait2_q <= resetn ? wait2_d : 1'b0;
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_rd_phase; dmem_rd ##1 !dmem_rd ##1 !dmem_rd; endsequence
  sequence s_wr_back; ##2 (dmem_we && dmem_wdata == $past(dmem_rdata)); endsequence
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  property p_one_cycle; take |=> !instr_ready[*3] ##1 instr_ready; endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("cycle length");
  property p_file_rd; file_take |=> s_rd_phase; endproperty
  a_file_rd: assert property (p_file_rd) else $error("read strobe");
  property p_rd_cause; dmem_rd |-> $past(file_take); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("stray read");
  property p_keep_file; file_take && !instr_word[9] |=> !dmem_we[*3]; endproperty
  a_keep_file: assert property (p_keep_file) else $error("file written");
  property p_write_back; file_take && instr_word[9] && instr_word[15:10] == `OMPL_OPC_MOVE |=> s_wr_back; endproperty
  a_write_back: assert property (p_write_back) else $error("no write back");
  property p_faddr; file_take |=> dmem_addr[7:0] == $past(f); endproperty
  a_faddr: assert property (p_faddr) else $error("file address");
  property p_access;
    file_take && !instr_word[8] |=>
      dmem_addr == (($past(f) < ACCESS_SPLIT) ? {`OMPL_ACCESS_LO, $past(f)} : {`OMPL_ACCESS_HI, $past(f)});
  endproperty
  a_access: assert property (p_access) else $error("access bank");
  property p_lit_quiet; take && !wait2_q && instr_word[15:8] == `OMPL_OPC_OR_LIT |=> (!dmem_rd && !dmem_we)[*4];
  endproperty
  a_lit_quiet: assert property (p_lit_quiet) else $error("memory touched");
  property p_pld_quiet; take && pld_one |=> (!dmem_rd && !dmem_we)[*4]; endproperty
  a_pld_quiet: assert property (p_pld_quiet) else $error("load touched memory");
endmodule
bind ompl_core ompl_checker #(.ACCESS_SPLIT(ACCESS_SPLIT), .NUM_PTRS(NUM_PTRS)) u_ompl_checker (
  .core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .instr_valid, .instr_word, .instr_ready,
  .dmem_addr, .dmem_rd, .dmem_we, .dmem_wdata, .dmem_rdata);
`default_nettype wire

// ---- bench/or_move_pointer_load_exec_tb.sv ----
// Purpose: Self-checking bench of the instruction executor
// Assumes: Bench is fetch, memory and bus master
// Notes:   Expected results queued, compared by a watcher
`timescale 1ns/10ps
`default_nettype none
`include "ompl_defs.svh"
module or_move_pointer_load_exec_tb;
  logic        core_clk    = 1'b0;  // Clock
  logic        resetn      = 1'b0;  // Reset
  logic        wb_cyc_i    = 1'b0;  // Bus cycle
  logic        wb_stb_i    = 1'b0;  // Bus strobe
  logic        wb_we_i     = 1'b0;  // Bus write
  logic [7:0]  wb_adr_i    = 8'h00; // Bus address
  logic [3:0]  wb_sel_i    = 4'h0;  // Byte enables
  logic [31:0] wb_dat_i    = 32'h0; // Write data
  logic        wb_ack_o;            // Bus answer
  logic [31:0] wb_dat_o;            // Read data
  logic        instr_valid = 1'b0;  // Word offered
  logic [15:0] instr_word  = 16'h0; // Offered word
  logic        instr_ready;         // Word taken
  logic [11:0] dmem_addr;           // Data address
  logic        dmem_rd;             // Data read
  logic        dmem_we;             // Data write
  logic [7:0]  dmem_wdata;          // Data to memory
  logic [7:0]  dmem_rdata  = 8'h00; // Data from memory
  logic [7:0]  mem [4096];          // Data memory model
  logic [1:0]  hold        = 2'h0;  // Read hold
  logic [31:0] pointer_literal_load        = 32'hE7B1B730;
  logic [31:0] rd_q [$];            // Expected bus reads
  logic [11:0] ra_q [$];            // Expected memory reads
  logic [19:0] wr_q [$];            // Expected memory writes
  logic [7:0]  a, k, f, v, r;       // Scenario values
  logic [11:0] ad;                  // Expected data address
  int          n_fail      = 0;
  int          total_checks = 0;

  ompl_core u_ompl_core (.core_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .wb_dat_o, .instr_valid, .instr_word, .instr_ready, .dmem_addr, .dmem_rd, .dmem_we,
    .dmem_wdata, .dmem_rdata);

  // Clock generator
  always #50 core_clk = ~core_clk;

  // ------
  // Helpers
  // ------
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int i);
    if (i >= 20) begin
      n_fail++;
      stop_test();
    end
  endtask
  function automatic logic [7:0] rnd();
    pointer_literal_load = {pointer_literal_load[30:0], pointer_literal_load[31] ^ pointer_literal_load[21] ^ pointer_literal_load[1] ^ pointer_literal_load[0]};
    return pointer_literal_load[7:0];
  endfunction
  function automatic logic [31:0] st(input logic [7:0] x);
    return {30'h0, x[7], x == 8'h00};
  endfunction
  // One classic bus cycle, held to ack
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    tmo(i);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, adr, 32'h0);
  endtask
  // Offer a word, wait for next Q1
  task automatic issue(input logic [15:0] w);
    int i;
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (instr_ready !== 1'b1 && i < 20);
    instr_valid <= 1'b0;
    instr_word  <= ~w;
    do begin
      @(posedge core_clk);
      i++;
    end while (instr_ready !== 1'b1 && i < 20);
    tmo(i);
  endtask

  // Data memory, data valid in Q3 and Q4
  always @(posedge core_clk) begin
    if (dmem_we === 1'b1) begin
      mem[dmem_addr] <= dmem_wdata;
    end
    if (dmem_rd === 1'b1) begin
      dmem_rdata <= mem[dmem_addr];
      hold       <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
  end

  // Compare each result with the oldest note
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      chk(wb_dat_o, rd_q.size() ? rd_q.pop_front() : 32'hX);
    end
    if (dmem_rd === 1'b1) begin
      chk({20'h0, dmem_addr}, ra_q.size() ? {20'h0, ra_q.pop_front()} : 32'hX);
    end
    if (dmem_we === 1'b1) begin
      chk({12'h0, dmem_addr, dmem_wdata}, wr_q.size() ? {12'h0, wr_q.pop_front()} : 32'hX);
    end
  end

  // ------
  // Main sequence
  // ------
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    // Reset values, last offset unmapped
    for (int n = 0; n < 8; n++) begin
      rd(8'(n * 4), n == 0 ? 32'h1 : 32'h0);
    end
    // OR literal, first pass zero
    for (int n = 0; n < 6; n++) begin
      a = n ? rnd() : 8'h00;
      k = n ? rnd() : 8'h00;
      bus(1'b1, `OMPL_OFS_ACC, {24'h0, a});
      issue({`OMPL_OPC_OR_LIT, k});
      rd(`OMPL_OFS_ACC, {24'h0, a | k});
      rd(`OMPL_OFS_STATUS, st(a | k));
    end
    // File ops over op, d, a and address half
    for (int n = 0; n < 16; n++) begin
      a = rnd();
      f = rnd();
      v = rnd();
      k = rnd();
      f[7] = n[3];
      ad = n[2] ? {k[3:0], f} : {(f < `OMPL_ACCESS_SPLIT) ? `OMPL_ACCESS_LO : `OMPL_ACCESS_HI, f};
      mem[ad] = v;
      r = n[0] ? v : (a | v);
      bus(1'b1, `OMPL_OFS_BANK, {28'h0, k[3:0]});
      bus(1'b1, `OMPL_OFS_ACC, {24'h0, a});
      ra_q.push_back(ad);
      if (n[1]) wr_q.push_back({ad, r});
      issue({n[0] ? `OMPL_OPC_MOVE : `OMPL_OPC_OR_FILE, n[1], n[2], f});
      rd(`OMPL_OFS_ACC, {24'h0, n[1] ? a : r});
      rd(`OMPL_OFS_STATUS, st(r));
      chk({24'h0, mem[ad]}, {24'h0, n[1] ? r : v});
    end
    // Pointer load, high part seen between words
    for (int s = 0; s < 3; s++) begin
      v = rnd();
      k = rnd();
      issue({`OMPL_OPC_PLD_FIRST, 2'(s), v[3:0]});
      rd(`OMPL_OFS_PTR0 + 8'(4 * s), {20'h0, v[3:0], 8'h00});
      issue({`OMPL_OPC_PLD_SECND, k});
      rd(`OMPL_OFS_PTR0 + 8'(4 * s), {20'h0, v[3:0], k});
    end
    rd(`OMPL_OFS_STATUS, st(r));
    // Bad second word and unknown word 16'hEEF0 are flagged, ACC kept
    issue({`OMPL_OPC_PLD_FIRST, 2'h0, 4'h5});
    issue(16'h0900);
    issue(16'hEEF0);
    rd(`OMPL_OFS_STATUS, st(r) | 32'hC);
    rd(`OMPL_OFS_ACC, {24'h0, a});
    repeat (2) @(posedge core_clk);
    chk(32'(rd_q.size() + ra_q.size() + wr_q.size()), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
